/* File: gpdrv_pkg.sv */
// Package: register map, field layout and reset values for the aux pin block
package gpdrv_pkg;
  localparam int unsigned NUM_PINS = 6;
  localparam logic [7:0] MODE_CFG_ADDR = 8'h16;
  localparam logic [7:0] DRIVE_LEVEL_ADDR = 8'h17;
  localparam int unsigned TW_ENABLE_BIT = 15;
  localparam int unsigned DIGITAL_EN_LSB = 8;
  localparam int unsigned DIRECTION_LSB = 0;
  localparam int unsigned OUT_LEVEL_LSB = 8;
  localparam int unsigned IN_LEVEL_LSB = 0;
  localparam logic TW_ENABLE_RESET = 1'b0;
  localparam logic [5:0] DIGITAL_EN_RESET = 6'h3f;
  localparam logic [5:0] DIRECTION_RESET = 6'h00;
  localparam logic [5:0] OUT_LEVEL_RESET = 6'h00;
  localparam logic [5:0] IN_LEVEL_RESET = 6'h00;
  localparam logic [5:0] TW_PIN_MASK = 6'h03;
  localparam int unsigned SDA_PIN = 0;
  localparam int unsigned SCL_PIN = 1;
endpackage

/* File: gpdrv_sync.sv */
// Two-stage synchroniser for the aux pin input buffers
module gpdrv_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] d,
  output logic [5:0] q
);
  logic [5:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 6'h00;
      q <= 6'h00;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: gpdrv_top.sv */
// Aux pin drive and readback: mode register, level register, pin control
// Functional notes
// RULE1 - Drive pin level only in digital output
// RULE2 - Output levels reset low, read back written
// RULE3 - Two-wire enable overrides output levels pins 0-1
// RULE4 - Input levels read only, reset zero
// RULE5 - Input level shown digital mode, else zero
// RULE6 - Snapshot inputs at address parity end
// RULE7 - Two-wire enable forces input levels 1:0 to 00
// RULE8 - Digital enable and direction per pin, defaults
// RULE9 - Two-wire mode: pin0 data, pin1 clock, open drain
// RULE10 - Input buffer stays live in output mode
// RULE11 - Pin inputs synchronised before snapshot
module gpdrv_top (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_ADDR_PARITY_END,
  output logic [15:0] REG_RDATA,
  input wire logic [5:0] PIN_IN,
  output logic [5:0] PIN_OUT,
  output logic [5:0] PIN_OE_N,
  input wire logic TW_SDA_LOW,
  input wire logic TW_SCL_LOW,
  output logic TW_SDA_IN,
  output logic TW_ENABLE
);
  logic tw_en_q;
  logic [5:0] dig_en_q;
  logic [5:0] dir_q;
  logic [5:0] out_level_q;
  logic [5:0] pin_sync;
  logic [5:0] in_level;
  logic [5:0] pin_out_d;
  logic [5:0] pin_oe_n_d;
  logic [15:0] rdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser

  gpdrv_sync u_sync (
    .clk(CLOCK),
    .rst(RST),
    .d(PIN_IN),
    .q(pin_sync)
  ); // RULE11

  ////////////////////////////////////////////////////////////////////////////
  // Mode register: two-wire enable, digital enable, direction

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tw_en_q <= gpdrv_pkg::TW_ENABLE_RESET;
      dig_en_q <= gpdrv_pkg::DIGITAL_EN_RESET; // RULE8
      dir_q <= gpdrv_pkg::DIRECTION_RESET; // RULE8
    end else if (REG_WR && REG_ADDR == gpdrv_pkg::MODE_CFG_ADDR) begin
      tw_en_q <= REG_WDATA[gpdrv_pkg::TW_ENABLE_BIT];
      dig_en_q <= REG_WDATA[gpdrv_pkg::DIGITAL_EN_LSB +: 6]; // RULE8
      dir_q <= REG_WDATA[gpdrv_pkg::DIRECTION_LSB +: 6]; // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level register: only the output-level field is writable

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      out_level_q <= gpdrv_pkg::OUT_LEVEL_RESET; // RULE2
    end else if (REG_WR && REG_ADDR == gpdrv_pkg::DRIVE_LEVEL_ADDR) begin
      // Stored even in two-wire mode so software reads back its value
      out_level_q <= REG_WDATA[gpdrv_pkg::OUT_LEVEL_LSB +: 6]; // RULE2 RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin drive and input qualification

  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_pin
      // Input buffer runs in both directions, so driven levels are seen
      assign in_level[i] = dig_en_q[i] & pin_sync[i]
        & ~(tw_en_q & gpdrv_pkg::TW_PIN_MASK[i]); // RULE5 RULE7 RULE10

      always_comb begin
        if (tw_en_q && gpdrv_pkg::TW_PIN_MASK[i]) begin
          // Open drain: only ever pull low, release otherwise
          pin_out_d[i] = 1'b0; // RULE9
          if (i == gpdrv_pkg::SDA_PIN) begin
            pin_oe_n_d[i] = ~TW_SDA_LOW; // RULE9
          end else begin
            pin_oe_n_d[i] = ~TW_SCL_LOW; // RULE9
          end
        end else begin
          pin_out_d[i] = out_level_q[i]; // RULE1 RULE3
          pin_oe_n_d[i] = ~(dig_en_q[i] & dir_q[i]); // RULE1
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PIN_OUT <= 6'h00;
      PIN_OE_N <= 6'h3f;
      TW_SDA_IN <= 1'b1;
      TW_ENABLE <= 1'b0;
    end else begin
      PIN_OUT <= pin_out_d;
      PIN_OE_N <= pin_oe_n_d;
      TW_SDA_IN <= pin_sync[gpdrv_pkg::SDA_PIN];
      TW_ENABLE <= tw_en_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: captured once at the end of the address parity bit

  always_comb begin
    rdata_d = 16'h0000;
    if (REG_ADDR == gpdrv_pkg::MODE_CFG_ADDR) begin
      rdata_d[gpdrv_pkg::TW_ENABLE_BIT] = tw_en_q;
      rdata_d[gpdrv_pkg::DIGITAL_EN_LSB +: 6] = dig_en_q;
      rdata_d[gpdrv_pkg::DIRECTION_LSB +: 6] = dir_q;
    end else if (REG_ADDR == gpdrv_pkg::DRIVE_LEVEL_ADDR) begin
      rdata_d[gpdrv_pkg::OUT_LEVEL_LSB +: 6] = out_level_q; // RULE2
      rdata_d[gpdrv_pkg::IN_LEVEL_LSB +: 6] = in_level; // RULE4
    end
  end

  // Snapshot held through the data phase, so pin noise cannot tear a word
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 16'h0000; // RULE4
    end else if (REG_ADDR_PARITY_END) begin
      REG_RDATA <= rdata_d; // RULE6
    end
  end
endmodule

/* File: gpdrv_asserts.sv */
// Checker: port relations of the aux pin block
module gpdrv_chk (input logic CLOCK, RST, REG_WR, REG_ADDR_PARITY_END,
  input logic TW_ENABLE, TW_SDA_LOW, TW_SCL_LOW, input logic [7:0] REG_ADDR,
  input logic [15:0] REG_WDATA, REG_RDATA, input logic [5:0] PIN_OUT, PIN_OE_N);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  wire rd = REG_ADDR_PARITY_END;
  wire lv = REG_ADDR == gpdrv_pkg::DRIVE_LEVEL_ADDR;
  wire md = REG_ADDR == gpdrv_pkg::MODE_CFG_ADDR;
  wire [3:0] on = ~PIN_OE_N[5:2];
  // Pins settle two edges after a write, so no second write may intervene
  sequence mode_set; REG_WR && md ##1 !(REG_WR && md) [*2]; endsequence
  sequence tw_on(x); TW_ENABLE && x ##1 TW_ENABLE; endsequence
  chk_rd_stands: assert property (!rd |=> $stable(REG_RDATA))
    else $error("read data moved");
  chk_rd_reserved: assert property (rd && lv |=>
    {REG_RDATA[15:14], REG_RDATA[7:6]} == 4'h0) else $error("reserved set");
  // Enable flag lags the register by one edge, so skip a fresh mode write
  chk_tw_inputs: assert property (rd && lv && TW_ENABLE &&
    !$past(REG_WR && md) |=> REG_RDATA[1:0] == 2'h0)
    else $error("pin 0-1 input set");
  chk_level_back: assert property (REG_WR && lv ##1 !REG_WR ##1 rd && lv |=>
    REG_RDATA[13:8] == $past(REG_WDATA[13:8], 3)) else $error("level lost");
  chk_mode_drive: assert property (mode_set |=> on ==
    ($past(REG_WDATA[13:10], 3) & $past(REG_WDATA[5:2], 3)))
    else $error("wrong drive");
  chk_level_drive: assert property (REG_WR && lv ##1 !(REG_WR && lv) [*2] |=>
    (PIN_OUT[5:2] & on) == ($past(REG_WDATA[13:10], 3) & on))
    else $error("wrong level");
  chk_tw_flag: assert property (mode_set |=>
    TW_ENABLE == $past(REG_WDATA[15], 3)) else $error("wrong enable");
  chk_sda_pull: assert property (tw_on(TW_SDA_LOW) |->
    !PIN_OE_N[0] && !PIN_OUT[0]) else $error("data not pulled");
  chk_scl_free: assert property (tw_on(!TW_SCL_LOW) |-> PIN_OE_N[1])
    else $error("clock driven");
  chk_scl_pull: assert property (tw_on(TW_SCL_LOW) |->
    !PIN_OE_N[1] && !PIN_OUT[1]) else $error("clock not pulled");
endmodule
bind gpdrv_top gpdrv_chk i_chk (.*);

/* File: gpdrv_host.sv */
// Host model driving the decoded register link
module gpdrv_host (input logic clk, input logic [15:0] rd_data,
  output logic [7:0] addr, output logic wr, pe, output logic [15:0] wdata);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr, wr, pe, wdata} = '0;
  // Released data is inverted so a stale value cannot pass
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) {wdata, wr} <= {~d, 1'b0};
  endtask
  task automatic get(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk) {addr, pe} <= {a, 1'b1};
    @(posedge clk) pe <= 1'b0;
    #1 d = rd_data;
  endtask
endmodule

/* File: gpdrv_tb.sv */
// Testbench: aux pin drive and readback
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 1'b0, RST = 1'b1, REG_WR, REG_ADDR_PARITY_END, TW_SDA_IN;
  logic TW_SDA_LOW = 1'b0, TW_SCL_LOW = 1'b0, TW_ENABLE;
  logic [7:0] REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA;
  logic [5:0] PIN_IN = 6'h00, PIN_OUT, PIN_OE_N;
  int num_errors = 0, n_compared = 0;
  always #4 CLOCK = ~CLOCK;
  gpdrv_top i_dut (.*);
  gpdrv_host i_host (.clk(CLOCK), .rd_data(REG_RDATA), .addr(REG_ADDR),
    .wr(REG_WR), .pe(REG_ADDR_PARITY_END), .wdata(REG_WDATA));
  task automatic chk(string s, logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic rdc(string s, logic [7:0] a, logic [15:0] exp);
    logic [15:0] v;
    i_host.get(a, v);
    chk(s, v, exp);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_reset;
    rdc("lvl", 8'h17, 16'h0000);
    rdc("mode", 8'h16, 16'h3f00);
    chk("rst pins", {PIN_OE_N, 4'h0, PIN_OUT}, 16'hfc00);
  endtask
  // Low bits of the level write must be dropped, they are read only
  task automatic t_drive;
    @(posedge CLOCK) PIN_IN <= 6'h15;
    i_host.put(8'h16, 16'h3f3f);
    i_host.put(8'h17, 16'hffff);
    i_host.put(8'h17, 16'h2aff);
    rdc("lvl", 8'h17, 16'h2a15);
    chk("pins", {PIN_OE_N, 4'h0, PIN_OUT}, 16'h002a);
  endtask
  task automatic t_analog;
    i_host.put(8'h16, 16'h0c3f);
    rdc("lvl", 8'h17, 16'h2a04);
    chk("oe", {10'h0, PIN_OE_N}, 16'h0033);
  endtask
  task automatic t_twowire;
    @(posedge CLOCK) TW_SDA_LOW <= 1'b1;
    i_host.put(8'h16, 16'hbf3f);
    rdc("lvl", 8'h17, 16'h2a14);
    chk("pins", {PIN_OE_N, 4'h0, PIN_OUT}, 16'h0828);
    chk("sda in", {15'h0000, TW_SDA_IN}, 16'h0001);
    // Clock line is pulled low only while the controller asks for it
    @(posedge CLOCK) TW_SCL_LOW <= 1'b1;
    repeat (2) @(posedge CLOCK);
    chk("scl", {PIN_OE_N, 4'h0, PIN_OUT}, 16'h0028);
    TW_SCL_LOW <= 1'b0;
    rdc("mode", 8'h16, 16'hbf3f);
  endtask
  task automatic t_snap;
    i_host.put(8'h16, 16'h3f00);
    rdc("snap", 8'h17, 16'h2a15);
    @(posedge CLOCK) PIN_IN <= 6'h2a;
    repeat (4) @(posedge CLOCK);
    chk("hold", REG_RDATA, 16'h2a15);
    chk("sda in", {15'h0000, TW_SDA_IN}, 16'h0000);
    rdc("lvl", 8'h17, 16'h2a2a);
  endtask
  initial begin
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    t_reset;
    t_drive;
    t_analog;
    t_twowire;
    t_snap;
    end_sim;
  end
  // Tests need well under 100 cycles; this limit leaves a wide margin
  initial begin
    #20000;
    num_errors++;
    end_sim;
  end
endmodule
